/* verilog/cod_decoder.sv */
// Opcode decoder and executor for the 14-bit instruction words, with AHB-Lite registers.
//
// Our own choices: the address map and register access over AHB-Lite.
module cod_decoder #(
  parameter int STACK_DEPTH = 16
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  output logic             busy
);

  typedef struct packed {
    logic [1:0]       div;
    logic [13:0]      instr;
    logic             pend;
    logic [1:0]       left;
    logic [7:0]       acc, opnd, res;
    logic             dest_reg, mem_wr, skip;
    logic [1:0]       cycles;
    logic [7:0]       status;
    logic [1:0][15:0] ptr;
    logic [15:0]      addr;
    logic [6:0]       pc_upper;
    logic [7:0]       option;
    logic [14:0]      pc;
    logic             dph_act, dph_wr;
    logic [7:0]       dph_addr;
    logic [31:0]      rdata;
  } cod_state_t;

  cod_state_t      s_q, s_d;
  cod_pkg::cod_op_t op;

  logic        tick, exec, take, pn_k, pn_m, f_ind, is_ind, ind_extra;
  logic        bitv, skip_now, pc_mod, stk_push, stk_pop;
  logic [1:0]  cyc_total;
  logic [7:0]  k8, dec_r, inc_r;
  logic [9:0]  sub_f, sub_k;
  logic [14:0] stk_top;
  logic [15:0] k6sx, ind_addr, m_new, m_addr, ptr_sum;

  // Subtract b and a borrow from a; returns {carry, digit carry, result}.
  function automatic logic [9:0] cod_sub(input logic [7:0] a, input logic [7:0] b,
                                         input logic bin);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} - {1'b0, b} - {8'h00, bin};
    low  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
    return {~full[8], ~low[4], full[7:0]};
  endfunction : cod_sub

  // Register read mux; unmapped offsets read as zero.
  function automatic logic [31:0] cod_rmux(input cod_state_t s, input logic [7:0] a);
    logic b;
    b = s.pend | (s.left != 2'h0);
    case (a)
      cod_pkg::OFS_INSTR:  cod_rmux = 32'({b, 1'b0, s.instr});
      cod_pkg::OFS_ACC:    cod_rmux = 32'(s.acc);
      cod_pkg::OFS_OPND:   cod_rmux = 32'(s.opnd);
      cod_pkg::OFS_RESULT: cod_rmux = 32'({s.cycles, s.skip, s.mem_wr, s.dest_reg, s.res});
      cod_pkg::OFS_STATUS: cod_rmux = 32'(s.status);
      cod_pkg::OFS_PTR0:   cod_rmux = 32'(s.ptr[0]);
      cod_pkg::OFS_PTR1:   cod_rmux = 32'(s.ptr[1]);
      cod_pkg::OFS_PCUP:   cod_rmux = 32'(s.pc_upper);
      cod_pkg::OFS_OPTION: cod_rmux = 32'(s.option);
      cod_pkg::OFS_PC:     cod_rmux = 32'(s.pc);
      cod_pkg::OFS_ADDR:   cod_rmux = 32'(s.addr);
      default:             cod_rmux = 32'h0000_0000;
    endcase
  endfunction : cod_rmux

  // Opcode classification; anything unmatched decodes as idle.
  always_comb begin
    casez (s_q.instr)
      cod_pkg::PAT_SUBB:    op = cod_pkg::OP_SUBB;
      cod_pkg::PAT_XOR:     op = cod_pkg::OP_XOR;
      cod_pkg::PAT_DECSZ:   op = cod_pkg::OP_DECSZ;
      cod_pkg::PAT_INCSZ:   op = cod_pkg::OP_INCSZ;
      cod_pkg::PAT_BTCLR:   op = cod_pkg::OP_BTCLR;
      cod_pkg::PAT_BTSET:   op = cod_pkg::OP_BTSET;
      cod_pkg::PAT_ORLIT:   op = cod_pkg::OP_ORLIT;
      cod_pkg::PAT_SUBLIT:  op = cod_pkg::OP_SUBLIT;
      cod_pkg::PAT_PAGE:    op = cod_pkg::OP_PAGE;
      cod_pkg::PAT_BRACC:   op = cod_pkg::OP_BRACC;
      cod_pkg::PAT_CALLACC: op = cod_pkg::OP_CALLACC;
      cod_pkg::PAT_RETLIT:  op = cod_pkg::OP_RETLIT;
      cod_pkg::PAT_RET:     op = cod_pkg::OP_RET;
      cod_pkg::PAT_RETIRQ:  op = cod_pkg::OP_RETIRQ;
      cod_pkg::PAT_OPTLD:   op = cod_pkg::OP_OPTLD;
      cod_pkg::PAT_SLEEP:   op = cod_pkg::OP_SLEEP;
      cod_pkg::PAT_PTRADD:  op = cod_pkg::OP_PTRADD;
      cod_pkg::PAT_LDM:     op = cod_pkg::OP_LDM;
      cod_pkg::PAT_STM:     op = cod_pkg::OP_STM;
      cod_pkg::PAT_LDK:     op = cod_pkg::OP_LDK;
      cod_pkg::PAT_STK:     op = cod_pkg::OP_STK;
      default:              op = cod_pkg::OP_IDLE;
    endcase
  end

  // Instruction fields and the cycle enable.
  assign tick = (s_q.div == cod_pkg::DIV_LAST);
  assign exec = tick & s_q.pend & (s_q.left == 2'h0);
  assign take = hsel & htrans[1] & hready;
  assign k8   = s_q.instr[7:0];
  assign k6sx = {{10{s_q.instr[5]}}, s_q.instr[5:0]};
  assign pn_k = s_q.instr[6];
  assign pn_m = s_q.instr[2];
  assign dec_r = s_q.opnd - 8'h01;
  assign inc_r = s_q.opnd + 8'h01;
  assign bitv  = s_q.opnd[s_q.instr[9:7]];
  assign sub_f = cod_sub(s_q.opnd, s_q.acc, ~s_q.status[cod_pkg::ST_C]);
  assign sub_k = cod_sub(k8, s_q.acc, 1'b0);
  assign ptr_sum = s_q.ptr[pn_k] + k6sx;

  // Update mode: bit 0 picks decrement, bit 1 picks post-modify.
  assign m_new  = s_q.ptr[pn_m] + (s_q.instr[0] ? 16'hFFFF : 16'h0001);
  assign m_addr = s_q.instr[1] ? s_q.ptr[pn_m] : m_new;

  // Register-field ops aimed at file addresses 0 and 1 go through a pointer.
  assign f_ind = (s_q.instr[6:1] == 6'h00) &&
                 (op inside {cod_pkg::OP_SUBB, cod_pkg::OP_XOR, cod_pkg::OP_DECSZ,
                             cod_pkg::OP_INCSZ, cod_pkg::OP_BTCLR, cod_pkg::OP_BTSET});

  // Effective indirect address and the extra cycle for a high pointer.
  always_comb begin
    is_ind   = 1'b1;
    ind_addr = 16'h0000;
    case (op)
      cod_pkg::OP_LDM, cod_pkg::OP_STM: ind_addr = m_addr;
      cod_pkg::OP_LDK, cod_pkg::OP_STK: ind_addr = ptr_sum;
      default: begin
        is_ind   = f_ind;
        ind_addr = f_ind ? s_q.ptr[s_q.instr[0]] : 16'h0000;
      end
    endcase
  end
  assign ind_extra = is_ind & ind_addr[15];

  // Skip conditions, PC-changing ops and the cycle count.
  always_comb begin
    case (op)
      cod_pkg::OP_DECSZ: skip_now = (dec_r == 8'h00);
      cod_pkg::OP_INCSZ: skip_now = (inc_r == 8'h00);
      cod_pkg::OP_BTCLR: skip_now = ~bitv;
      cod_pkg::OP_BTSET: skip_now = bitv;
      default:           skip_now = 1'b0;
    endcase
  end
  assign pc_mod = op inside {cod_pkg::OP_BRACC, cod_pkg::OP_CALLACC, cod_pkg::OP_RETLIT,
                             cod_pkg::OP_RET, cod_pkg::OP_RETIRQ};
  assign cyc_total = 2'h1 + {1'b0, pc_mod | skip_now} + {1'b0, ind_extra};

  assign stk_push = exec & (op == cod_pkg::OP_CALLACC);
  assign stk_pop  = exec & (op inside {cod_pkg::OP_RETLIT, cod_pkg::OP_RET,
                                       cod_pkg::OP_RETIRQ});

  cod_stack #(.DEPTH (STACK_DEPTH), .WIDTH (15)) u_stack (
    .clk       (hclk),
    .rst_n     (hresetn),
    .push      (stk_push),
    .pop       (stk_pop),
    .push_data (s_q.pc + 15'h0001),
    .top       (stk_top)
  );

  // Next state: bus writes first, then execution, so hardware updates win.
  always_comb begin
    cod_state_t n;
    n = s_q;
    n.div = s_q.div + 2'h1;
    n.dph_act  = take;
    n.dph_wr   = hwrite;
    n.dph_addr = {haddr[7:2], 2'b00};
    if (s_q.dph_act && s_q.dph_wr) begin
      case (s_q.dph_addr)
        cod_pkg::OFS_INSTR: begin
          if (!busy) begin
            n.instr = hwdata[13:0];
            n.pend  = 1'b1;
          end
        end
        cod_pkg::OFS_ACC:    n.acc      = hwdata[7:0];
        cod_pkg::OFS_OPND:   n.opnd     = hwdata[7:0];
        cod_pkg::OFS_STATUS: n.status   = hwdata[7:0];
        cod_pkg::OFS_PTR0:   n.ptr[0]   = hwdata[15:0];
        cod_pkg::OFS_PTR1:   n.ptr[1]   = hwdata[15:0];
        cod_pkg::OFS_PCUP:   n.pc_upper = hwdata[6:0];
        cod_pkg::OFS_OPTION: n.option   = hwdata[7:0];
        cod_pkg::OFS_PC:     n.pc       = hwdata[14:0];
        default:             n.pend     = n.pend;
      endcase
    end
    // Trailing cycles of a multi-cycle instruction run as idle.
    if (tick && !exec && s_q.left != 2'h0) begin
      n.left = s_q.left - 2'h1;
    end
    if (exec) begin
      n.pend     = 1'b0;
      n.cycles   = cyc_total;
      n.left     = cyc_total - 2'h1;
      n.skip     = skip_now;
      n.dest_reg = 1'b0;
      n.mem_wr   = 1'b0;
      n.addr     = is_ind ? ind_addr : s_q.addr;
      n.pc       = s_q.pc + (skip_now ? 15'h0002 : 15'h0001);
      case (op)
        cod_pkg::OP_SUBB, cod_pkg::OP_XOR, cod_pkg::OP_DECSZ, cod_pkg::OP_INCSZ: begin
          case (op)
            cod_pkg::OP_SUBB: begin
              n.res = sub_f[7:0];
              n.status[cod_pkg::ST_C]  = sub_f[9];
              n.status[cod_pkg::ST_DC] = sub_f[8];
              n.status[cod_pkg::ST_Z]  = (sub_f[7:0] == 8'h00);
            end
            cod_pkg::OP_XOR: begin
              n.res = s_q.acc ^ s_q.opnd;
              n.status[cod_pkg::ST_Z] = (n.res == 8'h00);
            end
            cod_pkg::OP_DECSZ: n.res = dec_r;
            default:           n.res = inc_r;
          endcase
          // Destination bit chooses accumulator or the register itself.
          n.dest_reg = s_q.instr[7];
          if (!s_q.instr[7]) begin
            n.acc = n.res;
          end
        end
        cod_pkg::OP_BTCLR, cod_pkg::OP_BTSET: n.res = s_q.opnd;
        cod_pkg::OP_ORLIT: begin
          n.acc = s_q.acc | k8;
          n.status[cod_pkg::ST_Z] = (n.acc == 8'h00);
        end
        cod_pkg::OP_SUBLIT: begin
          n.acc = sub_k[7:0];
          n.status[cod_pkg::ST_C]  = sub_k[9];
          n.status[cod_pkg::ST_DC] = sub_k[8];
          n.status[cod_pkg::ST_Z]  = (sub_k[7:0] == 8'h00);
        end
        cod_pkg::OP_PAGE:    n.pc_upper = s_q.instr[6:0];
        cod_pkg::OP_BRACC:   n.pc = s_q.pc + 15'h0001 + {7'h00, s_q.acc};
        cod_pkg::OP_CALLACC: n.pc = {s_q.pc_upper, s_q.acc};
        cod_pkg::OP_RETLIT: begin
          n.acc = k8;
          n.pc  = stk_top;
        end
        cod_pkg::OP_RET:     n.pc = stk_top;
        cod_pkg::OP_RETIRQ: begin
          n.pc = stk_top;
          n.status[cod_pkg::ST_IRQEN] = 1'b1;
        end
        cod_pkg::OP_OPTLD:   n.option = s_q.acc;
        cod_pkg::OP_SLEEP: begin
          n.status[cod_pkg::ST_WDTEXP] = 1'b1;
          n.status[cod_pkg::ST_SLEPT]  = 1'b0;
          n.status[cod_pkg::ST_ASLEEP] = 1'b1;
        end
        cod_pkg::OP_PTRADD:  n.ptr[pn_k] = ptr_sum;
        cod_pkg::OP_LDM, cod_pkg::OP_STM: begin
          n.ptr[pn_m] = m_new;
          if (op == cod_pkg::OP_LDM) begin
            n.acc = s_q.opnd;
            n.status[cod_pkg::ST_Z] = (s_q.opnd == 8'h00);
          end else begin
            n.res    = s_q.acc;
            n.mem_wr = 1'b1;
          end
        end
        cod_pkg::OP_LDK: begin
          n.acc = s_q.opnd;
          n.status[cod_pkg::ST_Z] = (s_q.opnd == 8'h00);
        end
        cod_pkg::OP_STK: begin
          n.res    = s_q.acc;
          n.mem_wr = 1'b1;
        end
        default: n.res = s_q.res;
      endcase
    end
    // Read data is taken from the next state so a just-written value reads back.
    n.rdata = (take && !hwrite) ? cod_rmux(n, {haddr[7:2], 2'b00}) : 32'h0000_0000;
    s_d = n;
  end

  // Whole state registered at once.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q          <= '0;
      s_q.status   <= cod_pkg::STATUS_RST;
      s_q.option   <= cod_pkg::OPTION_RST;
      s_q.acc      <= cod_pkg::BYTE_RST;
      s_q.ptr[0]   <= cod_pkg::PTR_RST;
      s_q.ptr[1]   <= cod_pkg::PTR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Zero-wait-state slave: always ready, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.rdata;
  assign busy      = s_q.pend | (s_q.left != 2'h0);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence seq_three_quiet;
    !tick [*3];
  endsequence

  sequence seq_one_idle_then_done;
    (s_q.left == 2'h1) ##4 (s_q.left == 2'h0);
  endsequence

  chk_tick_every_four: assert property (
    tick |=> seq_three_quiet ##1 tick)
    else $error("Instruction cycle enable not every fourth clock.");

  chk_pc_change_idle: assert property (
    exec && pc_mod && !ind_extra |=> seq_one_idle_then_done)
    else $error("PC-changing instruction did not take exactly two cycles.");

  chk_skip_advance: assert property (
    exec && skip_now && !(s_q.dph_act && s_q.dph_wr) |=>
      s_q.pc == $past(s_q.pc) + 15'h0002 && s_q.skip)
    else $error("True skip did not advance PC by two.");

  chk_indirect_extra: assert property (
    exec && ind_extra && !pc_mod && !skip_now |=> s_q.left == 2'h1 && s_q.cycles == 2'h2)
    else $error("High pointer access did not add one cycle.");

  chk_xor_zero_flag: assert property (
    exec && op == cod_pkg::OP_XOR && !ind_extra |=>
      s_q.res == ($past(s_q.acc) ^ $past(s_q.opnd)) &&
      s_q.status[cod_pkg::ST_Z] == (s_q.res == 8'h00) && s_q.left == 2'h0)
    else $error("Exclusive OR result or zero flag wrong.");

  chk_page_latch: assert property (
    exec && op == cod_pkg::OP_PAGE |=> s_q.pc_upper == $past(s_q.instr[6:0]))
    else $error("Upper PC latch not loaded from literal.");

  chk_sleep_flags: assert property (
    exec && op == cod_pkg::OP_SLEEP |=> s_q.status[cod_pkg::ST_WDTEXP] &&
      !s_q.status[cod_pkg::ST_SLEPT] && s_q.status[cod_pkg::ST_ASLEEP])
    else $error("Standby entry did not update the flags.");

  chk_pointer_add: assert property (
    exec && op == cod_pkg::OP_PTRADD && !(s_q.dph_act && s_q.dph_wr) |=>
      s_q.ptr[$past(pn_k)] == $past(ptr_sum) && $stable(s_q.status))
    else $error("Pointer add wrong or flags touched.");

  chk_idle_keeps: assert property (
    exec && op == cod_pkg::OP_IDLE && !(s_q.dph_act && s_q.dph_wr) |=>
      $stable(s_q.acc) && $stable(s_q.status) && s_q.left == 2'h0)
    else $error("Unlisted word changed state or took extra cycles.");

endmodule : cod_decoder

/* verilog/cod_pkg.sv */
// Constants, opcode patterns and types shared by the 14-bit opcode decoder.
package cod_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_ACC    = 8'h04;
  localparam logic [7:0] OFS_OPND   = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_PTR0   = 8'h14;
  localparam logic [7:0] OFS_PTR1   = 8'h18;
  localparam logic [7:0] OFS_PCUP   = 8'h1C;
  localparam logic [7:0] OFS_OPTION = 8'h20;
  localparam logic [7:0] OFS_PC     = 8'h24;
  localparam logic [7:0] OFS_ADDR   = 8'h28;

  // Status register bit positions, and the busy bit of the instruction register.
  localparam int ST_C      = 0;
  localparam int ST_DC     = 1;
  localparam int ST_Z      = 2;
  localparam int ST_SLEPT  = 3;
  localparam int ST_WDTEXP = 4;
  localparam int ST_IRQEN  = 5;
  localparam int ST_ASLEEP = 6;
  localparam int INSTR_BUSY_BIT = 15;

  // Reset values.
  localparam logic [7:0]  STATUS_RST = 8'h18;
  localparam logic [7:0]  OPTION_RST = 8'hFF;
  localparam logic [7:0]  BYTE_RST   = 8'h00;
  localparam logic [15:0] PTR_RST    = 16'h0000;

  // Clock periods per instruction cycle and the divider's last count.
  localparam int         OSC_PER_CYC = 4;
  localparam logic [1:0] DIV_LAST    = 2'(OSC_PER_CYC - 1);

  // Opcode patterns for casez decode.
  localparam logic [13:0] PAT_SUBB    = 14'h3B??;
  localparam logic [13:0] PAT_XOR     = 14'h06??;
  localparam logic [13:0] PAT_DECSZ   = 14'h0B??;
  localparam logic [13:0] PAT_INCSZ   = 14'h0F??;
  localparam logic [13:0] PAT_BTCLR   = 14'b01_10??_????_????;
  localparam logic [13:0] PAT_BTSET   = 14'b01_11??_????_????;
  localparam logic [13:0] PAT_ORLIT   = 14'h38??;
  localparam logic [13:0] PAT_SUBLIT  = 14'h3C??;
  localparam logic [13:0] PAT_PAGE    = 14'b11_0001_1???_????;
  localparam logic [13:0] PAT_BRACC   = 14'h000B;
  localparam logic [13:0] PAT_CALLACC = 14'h000A;
  localparam logic [13:0] PAT_RETLIT  = 14'h34??;
  localparam logic [13:0] PAT_RET     = 14'h0008;
  localparam logic [13:0] PAT_RETIRQ  = 14'h0009;
  localparam logic [13:0] PAT_OPTLD   = 14'h0062;
  localparam logic [13:0] PAT_SLEEP   = 14'h0063;
  localparam logic [13:0] PAT_PTRADD  = 14'b11_0001_0???_????;
  localparam logic [13:0] PAT_LDM     = 14'b00_0000_0001_0???;
  localparam logic [13:0] PAT_STM     = 14'b00_0000_0001_1???;
  localparam logic [13:0] PAT_LDK     = 14'b11_1111_0???_????;
  localparam logic [13:0] PAT_STK     = 14'b11_1111_1???_????;

  // Decoded operation classes.
  typedef enum logic [4:0] {
    OP_IDLE    = 5'b00000, OP_SUBB   = 5'b00001, OP_XOR    = 5'b00010,
    OP_DECSZ   = 5'b00011, OP_INCSZ  = 5'b00100, OP_BTCLR  = 5'b00101,
    OP_BTSET   = 5'b00110, OP_ORLIT  = 5'b00111, OP_SUBLIT = 5'b01000,
    OP_PAGE    = 5'b01001, OP_BRACC  = 5'b01010, OP_CALLACC = 5'b01011,
    OP_RETLIT  = 5'b01100, OP_RET    = 5'b01101, OP_RETIRQ = 5'b01110,
    OP_OPTLD   = 5'b01111, OP_SLEEP  = 5'b10000, OP_PTRADD = 5'b10001,
    OP_LDM     = 5'b10010, OP_STM    = 5'b10011, OP_LDK    = 5'b10100,
    OP_STK     = 5'b10101
  } cod_op_t;

endpackage : cod_pkg

/* verilog/cod_stack.sv */
// Return-address stack with registered top-of-stack output.
module cod_stack #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 15
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] push_data,
  output logic      [WIDTH-1:0] top
);
  localparam int SPW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [SPW-1:0]              sp;
    logic [WIDTH-1:0]            top;
  } cod_stack_st_t;

  cod_stack_st_t s_q;
  cod_stack_st_t s_d;

  // The pointer wraps silently; overflow and underflow are not trapped.
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.sp] = push_data;
      s_d.sp          = s_q.sp + SPW'(1);
    end else if (pop) begin
      s_d.sp = s_q.sp - SPW'(1);
    end
    s_d.top = s_d.mem[s_d.sp - SPW'(1)];
  end

  // Whole state registered at once.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign top = s_q.top;

  chk_push_top_shows: assert property (@(posedge clk) disable iff (!rst_n)
    push |=> top == $past(push_data))
    else $error("Pushed address not shown on top of stack.");

endmodule : cod_stack

/* tb/cod_bus_master.sv */
// Register bus master model standing for the fetch side.
module cod_bus_master (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // The bus starts idle with word size fixed.
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // One single word transfer; each phase holds until hready is high.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? wd : ~hwdata; // A read drives the complement of the previous hwdata onto the bus.
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
endmodule : cod_bus_master

/* tb/test_cod_decoder.sv */
// Self-checking bench for the opcode decoder.
module test_cod_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, busy;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          n_mismatch = 0;
  int          checks_done = 0;
  cod_decoder DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .busy(busy));
  cod_bus_master BM (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // Clock at 40 ns.
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    BM.xfer(1'b1, a, d, rd);
  endtask : wr
  task automatic rc(input string w, input logic [7:0] a, input logic [31:0] m, e);
    BM.xfer(1'b0, a, 32'h0, rd);
    chk(w, e, rd & m);
  endtask : rc
  // Busy rises on the edge the write lands, so look only after that edge.
  task automatic run(input logic [13:0] w);
    int n;
    wr(cod_pkg::OFS_INSTR, {18'h0, w});
    n = 0;
    @(posedge hclk);
    while (busy !== 1'b0 && n < 40) begin
      @(posedge hclk);
      n++;
    end
    chk("busy", 32'h0, {31'h0, busy});
  endtask : run
  task automatic t_reset;
    rc("status", cod_pkg::OFS_STATUS, 32'hFF, 32'h18);
    rc("option", cod_pkg::OFS_OPTION, 32'hFF, 32'hFF);
    rc("unmapped", 8'h3C, 32'hFFFFFFFF, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    $display("test reset done");
  endtask : t_reset
  task automatic t_file;
    wr(cod_pkg::OFS_ACC, 32'h5A);
    wr(cod_pkg::OFS_OPND, 32'h3C);
    run(14'h06A0);
    rc("xor", cod_pkg::OFS_RESULT, 32'h1FFF, 32'h0966);
    run(14'h0620);
    rc("xor acc", cod_pkg::OFS_ACC, 32'hFF, 32'h66);
    wr(cod_pkg::OFS_OPND, 32'h01);
    run(14'h0B20);
    rc("dec", cod_pkg::OFS_RESULT, 32'h1FFF, 32'h1400);
    rc("pc skip", cod_pkg::OFS_PC, 32'h7FFF, 32'h4);
    wr(cod_pkg::OFS_OPND, 32'hFF);
    run(14'h0FA0);
    rc("inc", cod_pkg::OFS_RESULT, 32'h1FFF, 32'h1500);
    wr(cod_pkg::OFS_OPND, 32'h80);
    run(14'h1FA0);
    rc("bit set", cod_pkg::OFS_RESULT, 32'h1FFF, 32'h1480);
    run(14'h1BA0);
    rc("bit clr", cod_pkg::OFS_RESULT, 32'h1FFF, 32'h0880);
    $display("test file ops done");
  endtask : t_file
  task automatic t_ctl;
    logic [13:0] w [7] = '{14'h000B, 14'h000A, 14'h0008, 14'h000A, 14'h0009, 14'h000A,
                           14'h3412};
    logic [14:0] pc_exp [7] = '{15'h0121, 15'h0320, 15'h0122, 15'h0320, 15'h0123,
                                15'h0320, 15'h0124};
    wr(cod_pkg::OFS_ACC, 32'h00);
    run(14'h3800);
    rc("or z", cod_pkg::OFS_STATUS, 32'h04, 32'h04);
    // Calls are paired with returns so the stack never runs empty.
    wr(cod_pkg::OFS_PC, 32'h0100);
    wr(cod_pkg::OFS_ACC, 32'h20);
    wr(cod_pkg::OFS_PCUP, 32'h03);
    foreach (w[i]) begin
      run(w[i]);
      rc("two cyc", cod_pkg::OFS_RESULT, 32'h1800, 32'h1000);
      rc("pc", cod_pkg::OFS_PC, 32'h7FFF, {17'h0, pc_exp[i]});
    end
    rc("retlit", cod_pkg::OFS_ACC, 32'hFF, 32'h12);
    rc("irq en", cod_pkg::OFS_STATUS, 32'h20, 32'h20);
    run(14'h31D5);
    rc("page", cod_pkg::OFS_PCUP, 32'h7F, 32'h55);
    run(14'h0000);
    rc("idle", cod_pkg::OFS_RESULT, 32'h1800, 32'h0800);
    // A second word written while the two-cycle branch runs must be ignored.
    wr(cod_pkg::OFS_INSTR, 32'h000B);
    run(14'h3801);
    rc("refused", cod_pkg::OFS_INSTR, 32'hBFFF, 32'h000B);
    rc("refused acc", cod_pkg::OFS_ACC, 32'hFF, 32'h12);
    $display("test control done");
  endtask : t_ctl
  task automatic t_ind;
    wr(cod_pkg::OFS_PTR0, 32'h8000);
    wr(cod_pkg::OFS_ACC, 32'h77);
    run(14'h3F80);
    rc("store", cod_pkg::OFS_RESULT, 32'h1FFF, 32'h1277);
    rc("addr", cod_pkg::OFS_ADDR, 32'hFFFF, 32'h8000);
    run(14'h0680);
    rc("xor ind", cod_pkg::OFS_RESULT, 32'h1FFF, 32'h11F7);
    run(14'h3101);
    rc("ptr add", cod_pkg::OFS_PTR0, 32'hFFFF, 32'h8001);
    run(14'h0062);
    rc("option ld", cod_pkg::OFS_OPTION, 32'hFF, 32'h77);
    run(14'h0063);
    rc("standby", cod_pkg::OFS_STATUS, 32'h58, 32'h50);
    wr(cod_pkg::OFS_OPND, 32'h44);
    run(14'h3F3F);
    rc("ld ofs", cod_pkg::OFS_ACC, 32'hFF, 32'h44);
    rc("ld addr", cod_pkg::OFS_ADDR, 32'hFFFF, 32'h8000);
    rc("ld cyc", cod_pkg::OFS_RESULT, 32'h1800, 32'h1000);
    $display("test indirect done");
  endtask : t_ind
  task automatic t_arith;
    wr(cod_pkg::OFS_ACC, 32'h10);
    wr(cod_pkg::OFS_OPND, 32'h35);
    wr(cod_pkg::OFS_STATUS, 32'h00);
    run(14'h3B20);
    rc("subb", cod_pkg::OFS_ACC, 32'hFF, 32'h24);
    rc("subb flags", cod_pkg::OFS_STATUS, 32'h07, 32'h03);
    run(14'h3C03);
    rc("sublit", cod_pkg::OFS_ACC, 32'hFF, 32'hDF);
    rc("sublit flags", cod_pkg::OFS_STATUS, 32'h07, 32'h00);
    run(14'h3CDF);
    rc("sublit zero", cod_pkg::OFS_STATUS, 32'h07, 32'h07);
    wr(cod_pkg::OFS_PTR1, 32'h8000);
    wr(cod_pkg::OFS_OPND, 32'h9C);
    run(14'h0015);
    rc("ldm", cod_pkg::OFS_ACC, 32'hFF, 32'h9C);
    rc("ldm ptr", cod_pkg::OFS_PTR1, 32'hFFFF, 32'h7FFF);
    rc("ldm addr", cod_pkg::OFS_ADDR, 32'hFFFF, 32'h7FFF);
    rc("ldm cyc", cod_pkg::OFS_RESULT, 32'h1800, 32'h0800);
    run(14'h001E);
    rc("stm", cod_pkg::OFS_RESULT, 32'h1FFF, 32'h0A9C);
    rc("stm ptr", cod_pkg::OFS_PTR1, 32'hFFFF, 32'h8000);
    $display("test arithmetic done");
  endtask : t_arith
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  // Watchdog far beyond the few hundred cycles the tests need.
  initial begin
    #200000;
    n_mismatch++;
    close_out();
  end
  // Reset for 8 cycles, then the tests.
  initial begin
    hresetn = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_file();
    t_ctl();
    t_ind();
    t_arith();
    close_out();
  end
endmodule : test_cod_decoder
